/* File: dv/host_misc_checker.sv */
// port assertions for the host misc register group
`timescale 1ns/10ps
module host_misc_checker (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_wr_n,
  input  wire logic        i_bus_16bit,
  input  wire logic [31:0] o_data_out,
  input  wire logic        o_data_oe,
  input  wire logic        i_frame_dropped,
  input  wire logic        o_drop_halfway,
  input  wire logic        o_mac_req,
  input  wire logic        o_mac_rnw,
  input  wire logic [7:0]  o_mac_index,
  input  wire logic [31:0] o_mac_wdata,
  input  wire logic        i_mac_ack,
  input  wire logic [31:0] i_txf_word,
  input  wire logic        i_txf_valid,
  input  wire logic        o_txf_ready,
  input  wire logic [15:0] o_net_tx_half,
  input  wire logic        o_net_tx_valid,
  input  wire logic        i_net_tx_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // sequences
  sequence s_tx_load;
    i_txf_valid && o_txf_ready;
  endsequence
  sequence s_tx_low_taken;
    s_tx_load ##1 (o_net_tx_valid && i_net_tx_ready);
  endsequence

  // ==========================================================================
  // properties
  property p_reset_vals;
    $fell(i_rst) |-> !o_mac_req && !o_mac_rnw && o_mac_index == 8'h00
      && o_mac_wdata == 32'h00000000 && !o_data_oe;
  endproperty
  property p_start_clean;
    $rose(o_mac_req) |-> !i_mac_ack && i_wr_n;
  endproperty
  property p_req_wait;
    $rose(i_mac_ack) |-> o_mac_req ##1 o_mac_req;
  endproperty
  property p_req_done;
    i_mac_ack && o_mac_req |-> ##[1:4] !o_mac_req;
  endproperty
  property p_args_stable;
    o_mac_req && $past(o_mac_req) |-> $stable(o_mac_rnw) && $stable(o_mac_index)
      && $stable(o_mac_wdata);
  endproperty
  property p_half16;
    i_bus_16bit && o_data_oe |-> o_data_out[31:16] == 16'h0000;
  endproperty
  property p_tx_low;
    s_tx_load |=> o_net_tx_valid && o_net_tx_half == $past(i_txf_word[15:0]);
  endproperty
  property p_tx_high;
    s_tx_low_taken |=> o_net_tx_valid && o_net_tx_half == $past(i_txf_word[31:16], 2);
  endproperty
  property p_halfway;
    o_drop_halfway |-> ($past(i_frame_dropped) || $past(i_frame_dropped, 2))
      ##1 !o_drop_halfway;
  endproperty

  a_reset_vals: assert property (p_reset_vals)
    else $error("indirect outputs wrong after reset");
  a_start_clean: assert property (p_start_clean)
    else $error("request raised without a finished command write");
  a_req_wait: assert property (p_req_wait)
    else $error("request dropped before ack was synchronised");
  a_req_done: assert property (p_req_done)
    else $error("request held too long after ack");
  a_args_stable: assert property (p_args_stable)
    else $error("indirect access fields changed during request");
  a_half16: assert property (p_half16)
    else $error("upper data lines driven in 16-bit mode");
  a_tx_low: assert property (p_tx_low)
    else $error("low halfword not sent first");
  a_tx_high: assert property (p_tx_high)
    else $error("high halfword not sent second");
  a_halfway: assert property (p_halfway)
    else $error("halfway pulse without a dropped frame");
endmodule

bind host_misc_csr_group host_misc_checker u_chk (
  .i_clk_sys, .i_rst, .i_wr_n, .i_bus_16bit, .o_data_out, .o_data_oe, .i_frame_dropped,
  .o_drop_halfway, .o_mac_req, .o_mac_rnw, .o_mac_index, .o_mac_wdata, .i_mac_ack,
  .i_txf_word, .i_txf_valid, .o_txf_ready, .o_net_tx_half, .o_net_tx_valid, .i_net_tx_ready
);

/* File: dv/mac_csr_model.sv */
// behavioural mac register space answering the four-phase indirect handshake
`timescale 1ns/10ps
module mac_csr_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_req,
  input  wire logic        i_rnw,
  input  wire logic [7:0]  i_index,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [256];
  logic [3:0]  cnt_q;
  logic        ack_q;
  logic [31:0] last_q;

  // each phase waits i_delay cycles before ack follows req
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (i_req != ack_q) begin
      if (cnt_q < i_delay) begin
        cnt_q <= cnt_q + 4'h1;
      end else begin
        cnt_q <= 4'h0;
        ack_q <= i_req;
        if (i_req && !i_rnw) begin
          mem[i_index] <= i_wdata;
        end
        if (i_req) begin
          last_q <= mem[i_index];
        end
      end
    end
  end

  assign o_ack   = ack_q;
  // read value only holds while ack is high
  assign o_rdata = ack_q ? last_q : ~last_q;
endmodule

/* File: dv/tb_host_misc_csr_group.sv */
// self-checking testbench for the host misc register group
`timescale 1ns/10ps
module tb_host_misc_csr_group;
  import host_misc_pkg::*;

  logic        clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, b16 = 1'b0;
  logic [7:1]  addr = 7'h00;
  logic [31:0] din = 32'h0, dout, wdata, rdata, txw = 32'h0, rxw;
  logic [15:0] timer = 16'h1234, txh, rxh = 16'h0;
  logic        fdrop = 1'b0, oe, halfway, req, rnw, ack, txv = 1'b0, txrdy, txval;
  logic        ntr = 1'b0, rxv = 1'b0, rxval;
  logic [7:0]  idx;
  logic [3:0]  dly = 4'h0;
  int          errors = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  host_misc_csr_group DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_bus_16bit(b16), .i_addr(addr), .i_data_in(din), .o_data_out(dout), .o_data_oe(oe),
    .i_timer_count(timer), .i_frame_dropped(fdrop), .o_drop_halfway(halfway),
    .o_mac_req(req), .o_mac_rnw(rnw), .o_mac_index(idx), .o_mac_wdata(wdata),
    .i_mac_ack(ack), .i_mac_rdata(rdata), .i_txf_word(txw), .i_txf_valid(txv),
    .o_txf_ready(txrdy), .o_net_tx_half(txh), .o_net_tx_valid(txval),
    .i_net_tx_ready(ntr), .i_net_rx_half(rxh), .i_net_rx_valid(rxv), .o_rxf_word(rxw),
    .o_rxf_valid(rxval));

  mac_csr_model u_mac (
    .i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_rnw(rnw), .i_index(idx),
    .i_wdata(wdata), .i_delay(dly), .o_ack(ack), .o_rdata(rdata));

  // ==========================================================================
  // reporting
  task automatic miss(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) miss($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic chk_ok(input logic c, input string m);
    compares++;
    if (c !== 1'b1) miss(m);
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // host bus access
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int i;
    i = 0;
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a[7:1];
    do begin
      @(posedge clk);
      i++;
    end while (oe !== 1'b1 && i < 20);
    if (i >= 20) begin
      miss("read hang");
      end_of_test;
    end
    v = dout;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    cyc(3);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    addr <= a[7:1];
    din  <= v;
    cyc(5);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    cyc(4);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] v;
    rd(a, v);
    chk(v, e, m);
  endtask
  task automatic drops(input int n);
    repeat (n) begin
      fdrop <= 1'b1;
      @(posedge clk);
      fdrop <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic wait_idle;
    logic [31:0] v;
    int i;
    i = 0;
    do begin
      rd(OFF_MAC_CMD, v);
      i++;
    end while (v[31] !== 1'b0 && i < 40);
    if (i >= 40) begin
      miss("busy hang");
      end_of_test;
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] v, t0, t1, tc;
    logic [31:0] q[$];
    int i;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_TICK_COUNT, v);
    chk_ok(v <= 32'h4, "tick not from zero");
    wr(8'h94, 32'hffffffff);
    wr(OFF_TIMER_COUNT, 32'h00005555);
    rdchk(8'h94, 32'h0, "unmapped");
    rdchk(OFF_TIMER_COUNT, {16'h0000, 16'h1234}, "timer view");
    timer <= 16'hbeef;
    rdchk(OFF_TIMER_COUNT, 32'h0000beef, "timer follows");
    rdchk(OFF_HALF_ORDER, HALF_ORDER_RST, "order reset");
    rdchk(OFF_MAC_CMD, 32'h0, "command reset");
    rdchk(OFF_MAC_DATA, MAC_DATA_RST, "data reset");
    wr(OFF_MAC_DATA, 32'hdeadbeef);
    wr(OFF_MAC_CMD, 32'h9fffff12);
    wait_idle;
    chk(u_mac.mem[8'h12], 32'hdeadbeef, "mac write");
    rdchk(OFF_MAC_CMD, 32'h00000012, "command after write");
    dly <= 4'hf;
    wr(OFF_MAC_DATA, 32'h0);
    wr(OFF_MAC_CMD, 32'hc0000012);
    rd(OFF_MAC_CMD, v);
    chk({31'h0, v[31]}, 32'h1, "busy not set");
    wait_idle;
    rdchk(OFF_MAC_DATA, 32'hdeadbeef, "mac read");
    rd(OFF_TICK_COUNT, t0);
    cyc(400);
    rd(OFF_TICK_COUNT, t1);
    chk_ok(t1 - t0 >= 32'd100 && t1 - t0 <= 32'd106, "tick rate");
    wr(OFF_MAC_DATA, 32'ha1b2c3d4);
    b16 <= 1'b1;
    cyc(4);
    rdchk(OFF_MAC_DATA, 32'h0000c3d4, "low half");
    rdchk(OFF_MAC_DATA | 8'h02, 32'h0000a1b2, "high half");
    wr(OFF_HALF_ORDER, 32'h0000ffff);
    wr(OFF_HALF_ORDER | 8'h02, 32'h0000ffff);
    rdchk(OFF_MAC_DATA, 32'h0000a1b2, "swapped high half");
    rdchk(OFF_MAC_DATA | 8'h02, 32'h0000c3d4, "swapped low half");
    drops(3);
    rdchk(OFF_DROP_TALLY | 8'h02, 32'h3, "16-bit drop low half");
    rdchk(OFF_DROP_TALLY, 32'h0, "16-bit drop high half");
    rd(OFF_TICK_COUNT, v);
    cyc(200);
    rd(OFF_TICK_COUNT | 8'h02, t0);
    tc = {v[15:0], t0[15:0]};
    b16 <= 1'b0;
    cyc(4);
    rd(OFF_TICK_COUNT, t1);
    chk_ok(t1 - tc >= 32'd50 && t1 - tc <= 32'd60, "tick snapshot");
    rdchk(OFF_MAC_DATA, 32'ha1b2c3d4, "32-bit order");
    drops(5);
    rdchk(OFF_DROP_TALLY, 32'h5, "drop count");
    rdchk(OFF_DROP_TALLY, 32'h0, "drop clear");
    ntr <= 1'b1;
    txw <= 32'h56781234;
    txv <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (txrdy !== 1'b1 && i < 10);
    if (txrdy !== 1'b1) begin
      miss("transmit hang");
      end_of_test;
    end
    txv <= 1'b0;
    txw <= 32'ha987edcb;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (txval === 1'b1) q.push_back({16'h0000, txh});
    end
    chk(32'(q.size()), 32'h2, "tx halves");
    chk(q[0], 32'h1234, "tx first");
    chk(q[1], 32'h5678, "tx second");
    rxv <= 1'b1;
    rxh <= 16'haaaa;
    @(posedge clk);
    rxh <= 16'hbbbb;
    @(posedge clk);
    rxv <= 1'b0;
    rxh <= 16'h4444;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rxval !== 1'b1 && i < 10);
    chk_ok(rxval, "rx word missing");
    chk(rxw, 32'hbbbbaaaa, "rx word");
    end_of_test;
  end
endmodule

/* File: hdl/bit_sync.sv */
// two flip-flop synchroniser, one per bit
`timescale 1ns/10ps
module bit_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // ==========================================================================
  // per-bit stages
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          meta_q <= RST_VAL[g];
          sync_q <= RST_VAL[g];
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule

/* File: hdl/host_misc_csr_group.sv */
// host misc control/status registers, indirect mac access and halfword ordering
`timescale 1ns/10ps

module host_misc_csr_group
  import host_misc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // host pins
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_bus_16bit,
  input  wire logic [7:1]  i_addr,
  input  wire logic [31:0] i_data_in,
  output logic      [31:0] o_data_out,
  output logic             o_data_oe,
  // timer and receive events
  input  wire logic [15:0] i_timer_count,
  input  wire logic        i_frame_dropped,
  output logic             o_drop_halfway,
  // indirect mac register access
  output logic             o_mac_req,
  output logic             o_mac_rnw,
  output logic      [7:0]  o_mac_index,
  output logic      [31:0] o_mac_wdata,
  input  wire logic        i_mac_ack,
  input  wire logic [31:0] i_mac_rdata,
  // transmit fifo word to network halfwords
  input  wire logic [31:0] i_txf_word,
  input  wire logic        i_txf_valid,
  output logic             o_txf_ready,
  output logic      [15:0] o_net_tx_half,
  output logic             o_net_tx_valid,
  input  wire logic        i_net_tx_ready,
  // network halfwords to receive fifo word
  input  wire logic [15:0] i_net_rx_half,
  input  wire logic        i_net_rx_valid,
  output logic      [31:0] o_rxf_word,
  output logic             o_rxf_valid
);

  // ==========================================================================
  // pin synchronisers
  logic [HOST_PIN_W-1:0] pins_sync;
  logic                  ack_sync;

  bit_sync #(
    .W       (HOST_PIN_W),
    .RST_VAL (HOST_PIN_RST)
  ) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_cs_n, i_rd_n, i_wr_n, i_bus_16bit, i_addr, i_data_in}),
    .o_sync    (pins_sync)
  );

  bit_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_ack_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (i_mac_ack),
    .o_sync    (ack_sync)
  );

  wire        s_cs_n  = pins_sync[42];
  wire        s_rd_n  = pins_sync[41];
  wire        s_wr_n  = pins_sync[40];
  wire        bus16   = pins_sync[39];
  wire  [6:0] s_addr  = pins_sync[38:32];
  wire [31:0] s_data  = pins_sync[31:0];

  // ==========================================================================
  // registers
  logic [15:0] timer_cnt_q;
  logic [31:0] half_order_q;
  logic [31:0] tick_cnt_q;
  logic [1:0]  tick_div_q;
  logic [31:0] drop_cnt_q;
  logic        halfway_q;
  logic        cmd_dir_q;
  logic [7:0]  cmd_index_q;
  logic [31:0] mac_data_q;
  mac_state_e  mac_state_q;
  mac_state_e  mac_state_d;
  logic [31:0] snap_q;
  logic        snap_pend_q;
  logic [7:0]  snap_off_q;
  logic [31:0] rdata_q;
  logic        rd_act_q;
  logic        wr_act_q;
  logic [6:0]  lat_addr_q;
  logic [31:0] lat_data_q;
  logic [15:0] tx_half_q;
  logic [15:0] tx_hi_q;
  logic        tx_phase_q;
  logic        tx_full_q;
  logic [15:0] rx_lo_q;
  logic        rx_phase_q;
  logic [31:0] rxf_word_q;
  logic        rxf_valid_q;

  // ==========================================================================
  // strobe decode
  wire rd_act   = !s_cs_n && !s_rd_n;
  wire wr_act   = !s_cs_n && !s_wr_n;
  wire rd_start = rd_act && !rd_act_q;
  wire wr_end   = wr_act_q && !wr_act;

  // halfword selection
  wire       half_rev = (half_order_q == HALF_ORDER_REVERSE);
  wire       rd_hi    = bus16 && (s_addr[0] ^ half_rev);
  wire       wr_hi    = bus16 && (lat_addr_q[0] ^ half_rev);
  wire [7:0] rd_off   = {s_addr[6:1], 2'b00};
  wire [7:0] wr_off   = {lat_addr_q[6:1], 2'b00};

  // ==========================================================================
  // read path
  wire        busy     = (mac_state_q != MAC_IDLE);
  wire [31:0] cmd_view = {busy, cmd_dir_q, 22'h000000, cmd_index_q};
  wire        rd_is_tick = (rd_off == OFF_TICK_COUNT);
  wire        rd_is_drop = (rd_off == OFF_DROP_TALLY);

  wire [31:0] rd_live =
    (rd_off == OFF_TIMER_COUNT) ? {16'h0000, timer_cnt_q} :
    (rd_off == OFF_HALF_ORDER)  ? half_order_q :
    rd_is_tick                  ? tick_cnt_q :
    rd_is_drop                  ? drop_cnt_q :
    (rd_off == OFF_MAC_CMD)     ? cmd_view :
    (rd_off == OFF_MAC_DATA)    ? mac_data_q :
                                  32'h00000000;

  // 16-bit reads of the counters pair up through one snapshot
  wire        rd_snap_reg = bus16 && (rd_is_tick || rd_is_drop);
  wire        use_snap    = rd_snap_reg && snap_pend_q && (snap_off_q == rd_off);
  wire        take_snap   = rd_start && rd_snap_reg && !use_snap;
  wire [31:0] rd_word     = use_snap ? snap_q : rd_live;
  wire [31:0] rd_out      = bus16 ? {16'h0000, rd_hi ? rd_word[31:16] : rd_word[15:0]}
                                  : rd_word;
  wire        drop_clr    = rd_start && rd_is_drop && (!bus16 || take_snap);

  // ==========================================================================
  // write path
  wire [31:0] wr_cur =
    (wr_off == OFF_HALF_ORDER) ? half_order_q :
    (wr_off == OFF_MAC_CMD)    ? cmd_view :
                                 mac_data_q;
  wire [31:0] wr_word = !bus16 ? lat_data_q :
                        wr_hi  ? {lat_data_q[15:0], wr_cur[15:0]} :
                                 {wr_cur[31:16], lat_data_q[15:0]};
  wire wr_order = wr_end && (wr_off == OFF_HALF_ORDER);
  wire wr_cmd   = wr_end && (wr_off == OFF_MAC_CMD) && !busy;
  wire wr_data  = wr_end && (wr_off == OFF_MAC_DATA) && !busy;
  wire mac_start = wr_cmd && wr_word[CMD_BUSY_BIT];
  wire rd_done   = (mac_state_q == MAC_REQ) && ack_sync;

  // ==========================================================================
  // host bus sequencing
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_act_q   <= 1'b0;
      wr_act_q   <= 1'b0;
      lat_addr_q <= 7'h00;
      lat_data_q <= 32'h00000000;
      rdata_q    <= 32'h00000000;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act) begin
        lat_addr_q <= s_addr;
        lat_data_q <= s_data;
      end
      if (rd_start) begin
        rdata_q <= rd_out;
      end
    end
  end

  assign o_data_out = rdata_q;
  assign o_data_oe  = rd_act && rd_act_q;

  // ==========================================================================
  // snapshot for paired halfword reads
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      snap_q      <= 32'h00000000;
      snap_pend_q <= 1'b0;
      snap_off_q  <= 8'h00;
    end else if (take_snap) begin
      snap_q      <= rd_live;
      snap_pend_q <= 1'b1;
      snap_off_q  <= rd_off;
    end else if (rd_start && use_snap) begin
      snap_pend_q <= 1'b0;
    end
  end

  // ==========================================================================
  // timer view, halfword order, tick counter
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      timer_cnt_q  <= TIMER_COUNT_RST;
      half_order_q <= HALF_ORDER_RST;
    end else begin
      timer_cnt_q <= i_timer_count;
      if (wr_order) begin
        half_order_q <= wr_word;
      end
    end
  end

  // no power-state gating reaches this counter
  wire tick_en = (tick_div_q == TICK_DIV_LAST);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_div_q <= 2'h0;
      tick_cnt_q <= TICK_COUNT_RST;
    end else begin
      tick_div_q <= tick_en ? 2'h0 : tick_div_q + 2'h1;
      if (tick_en) begin
        tick_cnt_q <= tick_cnt_q + 32'h00000001;
      end
    end
  end

  // ==========================================================================
  // dropped-frame tally; a drop in the clearing cycle is kept
  wire [31:0] drop_inc = {31'h00000000, i_frame_dropped};
  wire [31:0] drop_d   = drop_clr ? drop_inc : drop_cnt_q + drop_inc;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      drop_cnt_q <= DROP_TALLY_RST;
      halfway_q  <= 1'b0;
    end else begin
      drop_cnt_q <= drop_d;
      halfway_q  <= i_frame_dropped && !drop_clr &&
                    (drop_cnt_q == DROP_HALFWAY_FROM);
    end
  end

  assign o_drop_halfway = halfway_q;

  // ==========================================================================
  // indirect mac access
  always_comb begin
    mac_state_d = mac_state_q;
    unique case (mac_state_q)
      MAC_IDLE: begin
        if (mac_start) begin
          mac_state_d = MAC_REQ;
        end
      end
      MAC_REQ: begin
        if (ack_sync) begin
          mac_state_d = MAC_RELEASE;
        end
      end
      MAC_RELEASE: begin
        if (!ack_sync) begin
          mac_state_d = MAC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mac_state_q <= MAC_IDLE;
      cmd_dir_q   <= CMD_DIR_RST;
      cmd_index_q <= CMD_INDEX_RST;
      mac_data_q  <= MAC_DATA_RST;
    end else begin
      mac_state_q <= mac_state_d;
      if (wr_cmd) begin
        cmd_dir_q   <= wr_word[CMD_DIR_BIT];
        cmd_index_q <= wr_word[CMD_INDEX_MSB:CMD_INDEX_LSB];
      end
      if (rd_done && cmd_dir_q) begin
        mac_data_q <= i_mac_rdata;
      end else if (wr_data) begin
        mac_data_q <= wr_word;
      end
    end
  end

  assign o_mac_req   = (mac_state_q == MAC_REQ);
  assign o_mac_rnw   = cmd_dir_q;
  assign o_mac_index = cmd_index_q;
  assign o_mac_wdata = mac_data_q;

  // ==========================================================================
  // transmit: low halfword goes out first
  wire tx_load = i_txf_valid && !tx_full_q;
  wire tx_step = tx_full_q && i_net_tx_ready;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_half_q  <= 16'h0000;
      tx_hi_q    <= 16'h0000;
      tx_phase_q <= 1'b0;
      tx_full_q  <= 1'b0;
    end else if (tx_load) begin
      tx_half_q  <= i_txf_word[15:0];
      tx_hi_q    <= i_txf_word[31:16];
      tx_phase_q <= 1'b0;
      tx_full_q  <= 1'b1;
    end else if (tx_step) begin
      if (!tx_phase_q) begin
        tx_half_q  <= tx_hi_q;
        tx_phase_q <= 1'b1;
      end else begin
        tx_full_q  <= 1'b0;
      end
    end
  end

  assign o_txf_ready    = !tx_full_q;
  assign o_net_tx_half  = tx_half_q;
  assign o_net_tx_valid = tx_full_q;

  // ==========================================================================
  // receive: first halfword fills the low half
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_lo_q     <= 16'h0000;
      rx_phase_q  <= 1'b0;
      rxf_word_q  <= 32'h00000000;
      rxf_valid_q <= 1'b0;
    end else begin
      rxf_valid_q <= 1'b0;
      if (i_net_rx_valid) begin
        if (!rx_phase_q) begin
          rx_lo_q    <= i_net_rx_half;
          rx_phase_q <= 1'b1;
        end else begin
          rxf_word_q  <= {i_net_rx_half, rx_lo_q};
          rxf_valid_q <= 1'b1;
          rx_phase_q  <= 1'b0;
        end
      end
    end
  end

  assign o_rxf_word  = rxf_word_q;
  assign o_rxf_valid = rxf_valid_q;

endmodule

/* File: inc/host_misc_pkg.sv */
// constants, offsets, reset values and types for the host misc register group
package host_misc_pkg;

  // ==========================================================================
  // clocking
  localparam int          SYS_CLK_MHZ   = 100;
  localparam int          TICK_CLK_MHZ  = 25;
  localparam int          TICK_DIV      = SYS_CLK_MHZ / TICK_CLK_MHZ;
  localparam logic [1:0]  TICK_DIV_LAST = 2'(TICK_DIV - 1);

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0]  OFF_TIMER_COUNT = 8'h90;
  localparam logic [7:0]  OFF_HALF_ORDER  = 8'h98;
  localparam logic [7:0]  OFF_TICK_COUNT  = 8'h9c;
  localparam logic [7:0]  OFF_DROP_TALLY  = 8'ha0;
  localparam logic [7:0]  OFF_MAC_CMD     = 8'ha4;
  localparam logic [7:0]  OFF_MAC_DATA    = 8'ha8;

  // ==========================================================================
  // field positions
  localparam int          CMD_BUSY_BIT    = 31;
  localparam int          CMD_DIR_BIT     = 30;
  localparam int          CMD_INDEX_MSB   = 7;
  localparam int          CMD_INDEX_LSB   = 0;

  // ==========================================================================
  // reset and special values
  localparam logic [15:0] TIMER_COUNT_RST    = 16'hffff;
  localparam logic [31:0] HALF_ORDER_RST     = 32'h00000000;
  localparam logic [31:0] HALF_ORDER_REVERSE = 32'hffffffff;
  localparam logic [31:0] TICK_COUNT_RST     = 32'h00000000;
  localparam logic [31:0] DROP_TALLY_RST     = 32'h00000000;
  localparam logic [31:0] DROP_HALFWAY_FROM  = 32'h7fffffff;
  localparam logic        CMD_DIR_RST        = 1'b0;
  localparam logic [7:0]  CMD_INDEX_RST      = 8'h00;
  localparam logic [31:0] MAC_DATA_RST       = 32'h00000000;

  // ==========================================================================
  // host pin bundle: cs_n, rd_n, wr_n, bus_16bit, a[7:1], d[31:0]
  localparam int          HOST_PIN_W   = 43;
  localparam logic [42:0] HOST_PIN_RST = 43'h700_0000_0000;

  // ==========================================================================
  // indirect access handshake
  typedef enum logic [1:0] {
    MAC_IDLE,
    MAC_REQ,
    MAC_RELEASE
  } mac_state_e;

endpackage
